/* File: src/sbus_slave_interface.sv */
/*
  Bus slave interface: samples the bus on detected rising edges of the
  bus clock, decodes the address, buffers the transfer toward the local
  side and answers with the acknowledge and read data sequence.
  Assumes the core clock runs fast enough to see every bus clock level,
  and that the local side answers loc_req with a one-cycle loc_done.
*/
`timescale 1ns/1ps
`include "sbus_slave_map.svh"
module sbus_slave_interface #(
  parameter logic [7:0] MAX_WAIT = `SBS_MAX_WAIT
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic bus_clock,
  input wire logic bus_reset,
  input wire logic slot_select_n,
  input wire logic addr_strobe_n,
  input wire logic read_not_write,
  input wire logic [2:0] xfer_size,
  input wire logic [23:0] phys_addr,
  input wire logic [31:0] bus_data_in,
  output logic [31:0] bus_data_out,
  output logic bus_data_oe,
  output sbus_slave_pkg::ack_t xfer_ack_n,
  output logic xfer_ack_oe,
  output logic irq_out_n,
  output logic irq_out_oe,
  input wire logic vsync_irq,
  output logic loc_req,
  output logic loc_we,
  output logic [23:0] loc_addr,
  output logic [2:0] loc_size,
  output logic [31:0] loc_wdata,
  output sbus_slave_pkg::sel_t loc_sel,
  input wire logic [31:0] loc_rdata,
  input wire logic loc_done
);
  import sbus_slave_pkg::*;

  logic [63:0] raw;
  logic [63:0] smp;
  logic clk_d_r;
  logic edge_s;
  state_e st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [2:0] size_r, size_nxt;
  logic rnw_r, rnw_nxt;
  logic err_r, err_nxt;
  sel_t sel_r, sel_nxt;
  logic issued_r, issued_nxt;
  logic req_r, req_nxt;
  logic rd_ok_r, rd_ok_nxt;
  logic [31:0] rbuf_r, rbuf_nxt;
  ack_t ack_r, ack_nxt;
  logic ack_oe_r, ack_oe_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic dout_oe_r, dout_oe_nxt;
  logic irq_r;
  sel_t dec;
  logic burst;

  // All bus pins pass two flops before use; the bus clock rides in the same
  // bundle so data is taken in the same core cycle that its edge is seen.
  assign raw = {bus_clock, bus_reset, slot_select_n, addr_strobe_n, read_not_write,
                xfer_size, phys_addr, bus_data_in};

  sync_2ff #(.W(64)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d(raw),
    .q(smp)
  );

  // Rising edge of the synchronised bus clock paces every bus action except bus reset.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= smp[63];
    end
  end
  assign edge_s = smp[63] & ~clk_d_r;

  // Address decode into one-hot internal and external selects.
  always_comb begin
    dec = '0;
    if (smp[55]) begin
      dec[`SBS_SEL_FRAME] = 1'b1;
    end else if (smp[55:53] == 3'h0) begin
      dec[`SBS_SEL_ROM] = 1'b1;
    end else if (smp[55:51] == `SBS_DAC_TOP5) begin
      dec[`SBS_SEL_DAC] = 1'b1;
    end else begin
      case (smp[55:44])
        `SBS_ALT_PAGE: dec[`SBS_SEL_ALT] = 1'b1;
        `SBS_CFGA_PAGE: dec[`SBS_SEL_CFGA] = 1'b1;
        `SBS_CFGB_PAGE: dec[`SBS_SEL_CFGB] = 1'b1;
        `SBS_DRAW_PAGE: dec[`SBS_SEL_DRAW] = 1'b1;
        `SBS_XFORM_PAGE: dec[`SBS_SEL_XFORM] = 1'b1;
        default: dec = '0;
      endcase
    end
  end

  // Only single word, byte and halfword sizes are served; all else is burst.
  assign burst = (smp[58:56] != `SBS_SIZ_WORD) && (smp[58:56] != `SBS_SIZ_BYTE) &&
                 (smp[58:56] != `SBS_SIZ_HALF);

  // Success acknowledge code follows the transfer size.
  function automatic ack_t size_ack(input logic [2:0] s);
    case (s)
      `SBS_SIZ_BYTE: size_ack = `SBS_ACK_BYTE;
      `SBS_SIZ_HALF: size_ack = `SBS_ACK_HALF;
      default: size_ack = `SBS_ACK_WORD;
    endcase
  endfunction

  // Transfer sequencer; it only ever answers, it never starts a cycle.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    size_nxt = size_r;
    rnw_nxt = rnw_r;
    err_nxt = err_r;
    sel_nxt = sel_r;
    issued_nxt = issued_r;
    req_nxt = req_r;
    rd_ok_nxt = rd_ok_r;
    rbuf_nxt = rbuf_r;
    ack_nxt = ack_r;
    ack_oe_nxt = ack_oe_r;
    dout_nxt = dout_r;
    dout_oe_nxt = dout_oe_r;
    // Local handshake; a finished read parks its word for the bus.
    if (req_r && loc_done) begin
      req_nxt = 1'b0;
      // A late answer to a timed-out request must not feed the next read.
      if (rnw_r && issued_r) begin
        rd_ok_nxt = 1'b1;
        rbuf_nxt = loc_rdata;
      end
    end
    // Hand the buffered transfer on once the local side is free.
    if (st_r == ST_WAIT && !err_r && !issued_r && !req_r) begin
      req_nxt = 1'b1;
      issued_nxt = 1'b1;
    end
    if (edge_s) begin
      case (st_r)
        ST_IDLE: begin
          ack_oe_nxt = 1'b0;
          dout_oe_nxt = 1'b0;
          // Slot select and address strobe together qualify; a strobe without select is ignored.
          if (!smp[61] && !smp[60]) begin
            addr_nxt = smp[55:32];
            wdata_nxt = smp[31:0];
            size_nxt = smp[58:56];
            rnw_nxt = smp[59];
            sel_nxt = dec;
            err_nxt = burst || (dec == '0);
            rd_ok_nxt = 1'b0;
            issued_nxt = 1'b0;
            cnt_nxt = 8'h01;
            st_nxt = ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_nxt = cnt_r + 8'h01;
          ack_oe_nxt = 1'b1;
          ack_nxt = `SBS_ACK_IDLE;
          if (err_r && cnt_r >= `SBS_WR_ACK_CYC - 8'h01) begin
            ack_nxt = `SBS_ACK_ERR;
            st_nxt = ST_ACK;
          end else if (!err_r && !rnw_r && issued_r &&
                       cnt_r >= `SBS_WR_ACK_CYC - 8'h01) begin
            ack_nxt = size_ack(size_r);
            st_nxt = ST_ACK;
          end else if (!err_r && rnw_r && rd_ok_r && cnt_r >= `SBS_RD_ACK_MIN - 8'h01) begin
            ack_nxt = size_ack(size_r);
            st_nxt = ST_ACK;
          end else if (cnt_r >= MAX_WAIT - 8'h01) begin
            ack_nxt = `SBS_ACK_ERR;
            st_nxt = ST_ACK;
          end
        end
        ST_ACK: begin
          // Ack holds one bus cycle, then the idle code; read data follows.
          ack_nxt = `SBS_ACK_IDLE;
          if (rnw_r && rd_ok_r && !err_r) begin
            dout_nxt = rbuf_r;
            dout_oe_nxt = 1'b1;
          end
          st_nxt = ST_END;
        end
        ST_END: begin
          // Release only after a full idle cycle so no drivers overlap.
          ack_oe_nxt = 1'b0;
          dout_oe_nxt = 1'b0;
          st_nxt = ST_IDLE;
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
    // Bus reset drops the transfer and releases the lines at once.
    if (smp[62]) begin
      st_nxt = ST_IDLE;
      ack_oe_nxt = 1'b0;
      dout_oe_nxt = 1'b0;
      ack_nxt = `SBS_ACK_IDLE;
    end
  end

  // State registers, plus the interrupt input flop.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      addr_r <= 24'h000000;
      wdata_r <= 32'h00000000;
      size_r <= 3'h0;
      rnw_r <= 1'b0;
      err_r <= 1'b0;
      sel_r <= 8'h00;
      issued_r <= 1'b0;
      req_r <= 1'b0;
      rd_ok_r <= 1'b0;
      rbuf_r <= 32'h00000000;
      ack_r <= `SBS_ACK_IDLE;
      ack_oe_r <= 1'b0;
      dout_r <= 32'h00000000;
      dout_oe_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      size_r <= size_nxt;
      rnw_r <= rnw_nxt;
      err_r <= err_nxt;
      sel_r <= sel_nxt;
      issued_r <= issued_nxt;
      req_r <= req_nxt;
      rd_ok_r <= rd_ok_nxt;
      rbuf_r <= rbuf_nxt;
      ack_r <= ack_nxt;
      ack_oe_r <= ack_oe_nxt;
      dout_r <= dout_nxt;
      dout_oe_r <= dout_oe_nxt;
      irq_r <= vsync_irq;
    end
  end

  // Interrupt pulls low only; it is not tied to the bus clock at all.
  assign irq_out_n = 1'b0;
  assign irq_out_oe = irq_r;
  assign xfer_ack_n = ack_r;
  assign xfer_ack_oe = ack_oe_r;
  assign bus_data_out = dout_r;
  assign bus_data_oe = dout_oe_r;
  assign loc_req = req_r;
  assign loc_we = ~rnw_r;
  assign loc_addr = addr_r;
  assign loc_size = size_r;
  assign loc_wdata = wdata_r;
  assign loc_sel = sel_r;

  property p_ack_then_idle;
    @(posedge clock) disable iff (!nrst)
      (st_r == ST_ACK && edge_s && !smp[62]) |=> (ack_r == `SBS_ACK_IDLE && ack_oe_r);
  endproperty
  a_ack_then_idle: assert property (p_ack_then_idle) else $error("ack not followed by idle");

  property p_idle_before_release;
    @(posedge clock) disable iff (!nrst)
      $fell(ack_oe_r) |-> $past(ack_r) == `SBS_ACK_IDLE;
  endproperty
  a_idle_before_release: assert property (p_idle_before_release) else $error("ack released while asserted");

  property p_data_after_ack;
    @(posedge clock) disable iff (!nrst)
      $rose(dout_oe_r) |-> (ack_r == `SBS_ACK_IDLE && $past(ack_r) != `SBS_ACK_IDLE);
  endproperty
  a_data_after_ack: assert property (p_data_after_ack) else $error("read data not after ack");

  property p_data_one_cycle;
    @(posedge clock) disable iff (!nrst)
      (dout_oe_r && edge_s) |=> !dout_oe_r;
  endproperty
  a_data_one_cycle: assert property (p_data_one_cycle) else $error("read data held too long");

  property p_released_when_idle;
    @(posedge clock) disable iff (!nrst)
      (st_r == ST_IDLE && $past(st_r) == ST_IDLE) |-> (!ack_oe_r && !dout_oe_r);
  endproperty
  a_released_when_idle: assert property (p_released_when_idle) else $error("driving while idle");

  property p_write_ack_three;
    @(posedge clock) disable iff (!nrst)
      ($rose(st_r == ST_ACK) && !rnw_r && ack_r != `SBS_ACK_ERR) |-> cnt_r == `SBS_WR_ACK_CYC;
  endproperty
  a_write_ack_three: assert property (p_write_ack_three) else $error("write ack not at cycle three");

  property p_read_ack_min;
    @(posedge clock) disable iff (!nrst)
      ($rose(st_r == ST_ACK) && rnw_r && ack_r != `SBS_ACK_ERR) |-> cnt_r >= `SBS_RD_ACK_MIN;
  endproperty
  a_read_ack_min: assert property (p_read_ack_min) else $error("read ack too early");

  property p_ack_bound;
    @(posedge clock) disable iff (!nrst)
      $rose(st_r == ST_ACK) |-> cnt_r <= MAX_WAIT;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack later than limit");

  property p_burst_error;
    @(posedge clock) disable iff (!nrst)
      ($rose(st_r == ST_ACK) && err_r) |-> (ack_r == `SBS_ACK_ERR && !issued_r);
  endproperty
  a_burst_error: assert property (p_burst_error) else $error("bad transfer not error acked");

  property p_data_only_read;
    @(posedge clock) disable iff (!nrst)
      dout_oe_r |-> (rnw_r && ack_oe_r && ack_r == `SBS_ACK_IDLE);
  endproperty
  a_data_only_read: assert property (p_data_only_read) else $error("data driven outside read");

  property p_cov_write;
    @(posedge clock) disable iff (!nrst)
      $rose(st_r == ST_ACK) && !rnw_r && ack_r == `SBS_ACK_WORD;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_read;
    @(posedge clock) disable iff (!nrst) $rose(dout_oe_r);
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_error;
    @(posedge clock) disable iff (!nrst) $rose(st_r == ST_ACK) && ack_r == `SBS_ACK_ERR;
  endproperty
  c_cov_error: cover property (p_cov_error);
endmodule

/* File: src/sbus_slave_map.svh */
/*
  Constants of the bus slave interface: address map, size and acknowledge
  codes and cycle counts. Assumes inclusion by bare name from src/.
*/
// Behaviour
// - Act as slave only, never start transfers.
// - Accept single 1, 2, 4 byte transfers.
// - Provide 32-bit data path.
// - Decode 24-bit address into chip selects.
// - Slot select alone qualifies the slave; the code also requires address strobe low.
// - Sample all bus signals on rising bus clock; the code acts on bus reset in any core cycle.
// - Synchronise bus clock to local core clock.
// - Buffer writes for fast acknowledgment.
// - Single open-drain asynchronous interrupt output.
// - Drive control unasserted one cycle before release.
// - Never two drivers on a signal together.
// - Acknowledge writes within 255 bus cycles.
// - Ack one cycle, then idle, then release.
// - Read data follows ack for one cycle.
// - Burst attempt gets error acknowledgment.
// - Writes ack at three, reads five to seven; the code acks reads at five or later, once the local data is in.
`ifndef SBUS_SLAVE_MAP_SVH
`define SBUS_SLAVE_MAP_SVH
`define SBS_SIZ_WORD 3'h0
`define SBS_SIZ_BYTE 3'h1
`define SBS_SIZ_HALF 3'h2
`define SBS_ACK_IDLE 3'h7
`define SBS_ACK_ERR 3'h6
`define SBS_ACK_BYTE 3'h5
`define SBS_ACK_WORD 3'h3
`define SBS_ACK_HALF 3'h1
`define SBS_WR_ACK_CYC 8'h03
`define SBS_RD_ACK_MIN 8'h05
`define SBS_MAX_WAIT 8'hff
`define SBS_SEL_ROM 0
`define SBS_SEL_DAC 1
`define SBS_SEL_ALT 2
`define SBS_SEL_CFGA 3
`define SBS_SEL_CFGB 4
`define SBS_SEL_DRAW 5
`define SBS_SEL_XFORM 6
`define SBS_SEL_FRAME 7
`define SBS_DAC_TOP5 5'h04
`define SBS_ALT_PAGE 12'h280
`define SBS_CFGA_PAGE 12'h300
`define SBS_CFGB_PAGE 12'h301
`define SBS_DRAW_PAGE 12'h700
`define SBS_XFORM_PAGE 12'h701
`endif

/* File: src/sbus_slave_pkg.sv */
/*
  Types shared by the bus slave interface. Assumes nothing beyond the
  map header for its constants.
*/
package sbus_slave_pkg;
  typedef logic [2:0] ack_t;
  typedef logic [7:0] sel_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_ACK = 4'h4,
    ST_END = 4'h8
  } state_e;
endpackage

/* File: src/sync_2ff.sv */
/*
  Two flip-flop synchroniser for a bundle of levels. Assumes the inputs
  are asynchronous to clock and that only the second stage is read.
*/
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second stage.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

/* File: tb/bus_host_model.sv */
/*
  Bus controller model: runs single transfers on the slave's bus pins.
  Assumes the bench makes bus_clock and resolves the ack lines.
*/
`timescale 1ns/1ps
module bus_host_model (
  input wire logic bus_clock,
  input wire logic [2:0] ack_wire,
  output logic slot_select_n,
  output logic addr_strobe_n,
  output logic read_not_write,
  output logic [2:0] xfer_size,
  output logic [23:0] phys_addr,
  output logic [31:0] host_d
);
  // Idle bus at time zero.
  initial begin
    slot_select_n = 1'b1;
    addr_strobe_n = 1'b1;
    read_not_write = 1'b1;
    xfer_size = 3'h0;
    phys_addr = 24'h0;
    host_d = 32'h0;
  end
  // Launch after a falling edge so setup is met; hold until the ack is sampled, and one bus cycle longer on reads.
  task automatic xfer(input logic rd, input logic [2:0] sz, input logic [23:0] a,
                      input logic [31:0] d);
    logic [2:0] ack;
    int n;
    @(negedge bus_clock);
    phys_addr = a;
    slot_select_n = 1'b0;
    addr_strobe_n = 1'b0;
    read_not_write = rd;
    xfer_size = sz;
    host_d = rd ? ~host_d : d;
    ack = 3'h7;
    n = 0;
    while (ack === 3'h7 && n < 300) begin
      @(posedge bus_clock);
      ack = ack_wire;
      n++;
    end
    if (rd) @(posedge bus_clock);
    @(negedge bus_clock);
    slot_select_n = 1'b1;
    addr_strobe_n = 1'b1;
    phys_addr = ~phys_addr;
    host_d = ~host_d;
    repeat (2) @(posedge bus_clock);
  endtask
  // Strobe without select, which the slave must ignore.
  task automatic strobe_only();
    @(negedge bus_clock);
    addr_strobe_n = 1'b0;
    repeat (4) @(negedge bus_clock);
    addr_strobe_n = 1'b1;
  endtask
endmodule

/* File: tb/sbus_slave_interface_bench.sv */
/*
  Self-checking bench of the bus slave interface with a local responder.
  Assumes the design files and map header are compiled first.
*/
`timescale 1ns/1ps
`include "sbus_slave_map.svh"
module sbus_slave_interface_bench;
  import sbus_slave_pkg::*;
  typedef struct {logic rd; ack_t ack; logic [2:0] sz; logic [23:0] a;
                  logic [31:0] d; logic [7:0] sel; int lo; int hi;} note_s;
  localparam logic [7:0] MW = 8'h10;
  logic clock = 1'b0, nrst = 1'b0, bus_clock = 1'b0, bus_reset = 1'b0;
  logic slot_select_n, addr_strobe_n, read_not_write, vsync_irq = 1'b0;
  logic [2:0] xfer_size, loc_size, ack_wire;
  logic [23:0] phys_addr, loc_addr;
  logic [31:0] bus_data_out, host_d, data_wire, loc_wdata, loc_rdata = 32'h0;
  logic bus_data_oe, xfer_ack_oe, irq_out_n, irq_out_oe, loc_req, loc_we;
  logic loc_done = 1'b0, stall = 1'b0;
  ack_t xfer_ack_n;
  sel_t loc_sel;
  logic [15:0] lfsr = 16'hd88a;
  int bad_count = 0, checks = 0, cyc = 0, post = 0, dly = 0;
  note_s expq[$], locq[$], cur, ln;
  logic [23:0] base [11] = '{24'h000000, 24'h200000, 24'h280000, 24'h300000,
    24'h301000, 24'h700000, 24'h701000, 24'h800000, 24'h290000, 24'h302000, 24'h400000};
  always #25 clock = ~clock;
  // Bus clock is offset so its edges never line up with the core clock.
  initial begin
    #13;
    forever #200 bus_clock = ~bus_clock;
  end
  // Pull-ups hold the ack lines idle when nobody drives them.
  assign ack_wire = xfer_ack_oe ? xfer_ack_n : 3'h7;
  assign data_wire = bus_data_oe ? bus_data_out : host_d;
  sbus_slave_interface #(.MAX_WAIT(MW)) DUT (.clock(clock), .nrst(nrst),
    .bus_clock(bus_clock), .bus_reset(bus_reset), .slot_select_n(slot_select_n),
    .addr_strobe_n(addr_strobe_n), .read_not_write(read_not_write),
    .xfer_size(xfer_size), .phys_addr(phys_addr), .bus_data_in(data_wire),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .xfer_ack_n(xfer_ack_n),
    .xfer_ack_oe(xfer_ack_oe), .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe),
    .vsync_irq(vsync_irq), .loc_req(loc_req), .loc_we(loc_we), .loc_addr(loc_addr),
    .loc_size(loc_size), .loc_wdata(loc_wdata), .loc_sel(loc_sel),
    .loc_rdata(loc_rdata), .loc_done(loc_done));
  bus_host_model host (.bus_clock(bus_clock), .ack_wire(ack_wire),
    .slot_select_n(slot_select_n), .addr_strobe_n(addr_strobe_n),
    .read_not_write(read_not_write), .xfer_size(xfer_size),
    .phys_addr(phys_addr), .host_d(host_d));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [7:0] dec(input logic [23:0] a);
    if (a < 24'h200000) return 8'h01;
    if (a < 24'h280000) return 8'h02;
    if (a[23:12] == 12'h280) return 8'h04;
    if (a[23:12] == 12'h300) return 8'h08;
    if (a[23:12] == 12'h301) return 8'h10;
    if (a[23:12] == 12'h700) return 8'h20;
    if (a[23:12] == 12'h701) return 8'h40;
    if (a[23]) return 8'h80;
    return 8'h00;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Notes the expected answers, then hands the transfer to the host model.
  task automatic run(input logic rd, input logic [2:0] sz, input logic [23:0] a);
    note_s n;
    n = '{rd, `SBS_ACK_ERR, sz, a, {rnd(), rnd()}, dec(a), 3, 3};
    if (n.sel != 8'h00 && sz < 3'h3) begin
      n.ack = sz == 3'h0 ? `SBS_ACK_WORD : sz == 3'h1 ? `SBS_ACK_BYTE : `SBS_ACK_HALF;
      locq.push_back(n);
      if (stall) begin
        n = '{rd, `SBS_ACK_ERR, sz, a, n.d, n.sel, int'(MW), int'(MW)};
      end else if (rd) begin
        n.lo = 5;
        n.hi = 7;
      end
    end
    expq.push_back(n);
    host.xfer(rd, sz, a, n.d);
  endtask
  // Watches every rising bus edge: ack code and timing, idle cycle, release.
  always @(posedge bus_clock) begin
    if (nrst && post == 2) begin
      check(xfer_ack_oe, 0);
      check(bus_data_oe, 0);
      post = 0;
    end else if (nrst && post == 1) begin
      check(xfer_ack_n, 3'h7);
      check(xfer_ack_oe, 1);
      if (cur.rd && cur.ack != `SBS_ACK_ERR) begin
        check(bus_data_oe, 1);
        check(bus_data_out, cur.d);
      end else begin
        check(bus_data_oe, 0);
      end
      post = 2;
    end else if (nrst && slot_select_n === 1'b1) begin
      check(xfer_ack_oe | bus_data_oe, 0);
    end else if (nrst && xfer_ack_oe === 1'b1 && xfer_ack_n !== 3'h7) begin
      cur = expq.size() ? expq.pop_front() : note_s'{default: 'x};
      check(xfer_ack_n, cur.ack);
      check(cyc >= cur.lo && cyc <= cur.hi, 1);
      post = 1;
    end
    cyc = slot_select_n ? 0 : cyc + 1;
  end
  // Local side answers each request after a short random delay.
  always @(negedge clock) begin
    if (loc_req !== 1'b1 || loc_done === 1'b1 || stall) begin
      loc_done <= 1'b0;
    end else if (dly != 0) begin
      dly = dly - 1;
      loc_done <= 1'b0;
    end else begin
      ln = locq.size() ? locq.pop_front() : note_s'{default: 'x};
      check(loc_we, !ln.rd);
      check(loc_addr, ln.a);
      check(loc_size, ln.sz);
      check(loc_sel, ln.sel);
      if (!ln.rd) check(loc_wdata, ln.d);
      loc_rdata <= ln.d;
      loc_done <= 1'b1;
      dly = rnd() % 8;
    end
  end
  // A hang cuts the run short well past the expected length.
  initial begin
    #1000000;
    bad_count++;
    results();
  end
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (12) @(negedge clock);
    check(xfer_ack_oe | bus_data_oe | loc_req | irq_out_oe, 0);
    $display("test reset done");
    foreach (base[i]) for (int r = 0; r < 2; r++) begin
      run(r[0], 3'(rnd() % 3), base[i] | 24'(rnd() & 16'h0ffc));
    end
    $display("test map done");
    for (int s = 0; s < 8; s++) begin
      run(1'b0, 3'(s), 24'h700010);
      run(1'b1, 3'(s), 24'h800020);
    end
    $display("test sizes done");
    host.strobe_only();
    stall = 1'b1;
    run(1'b1, 3'h0, 24'h300040);
    stall = 1'b0;
    $display("test timeout done");
    vsync_irq = 1'b1;
    repeat (3) @(negedge clock);
    check(irq_out_oe, 1);
    check(irq_out_n, 0);
    vsync_irq = 1'b0;
    repeat (3) @(negedge clock);
    check(irq_out_oe, 0);
    bus_reset = 1'b1;
    repeat (20) @(negedge clock);
    bus_reset = 1'b0;
    repeat (20) @(negedge clock);
    run(1'b0, 3'h0, 24'h701000);
    run(1'b1, 3'h2, 24'h301008);
    $display("test irq and bus reset done");
    repeat (40) @(negedge clock);
    check(locq.size(), 0);
    check(expq.size(), 0);
    results();
  end
endmodule
